//--- ebpso_top.sv
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module ebpso_top #(
  parameter int PORT_W   = ebpso_pkg::PORT_W,
  parameter int PWM_CH_N = ebpso_pkg::PWM_CH_N
) (
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                RST_N,
  // AHB-Lite slave
  input  wire logic                HSEL,
  input  wire logic [31:0]         HADDR,
  input  wire logic [1:0]          HTRANS,
  input  wire logic                HWRITE,
  input  wire logic [2:0]          HSIZE,
  input  wire logic [31:0]         HWDATA,
  input  wire logic                HREADY,
  output logic      [31:0]         HRDATA,
  output logic                     HREADYOUT,
  output logic                     HRESP,
  // Port pins
  input  wire logic [PORT_W-1:0]   PIN_I,
  output logic      [PORT_W-1:0]   PIN_O,
  output logic      [PORT_W-1:0]   PIN_OE,
  // External processor strobes
  input  wire logic                SLAVE_RD,
  input  wire logic                SLAVE_WR,
  // PWM unit, same clock
  input  wire logic [PWM_CH_N-1:0] PWM_ACTIVE,
  input  wire logic [PWM_CH_N-1:0] PWM_OUT,
  input  wire logic                PWM_MULTI
);

  // ==========================================================================
  // Reset release
  logic rst_n_s1_ff;
  logic rst_n_s2_ff;
  logic rst_n;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_n_s1_ff <= 1'b0;
      rst_n_s2_ff <= 1'b0;
    end else begin
      rst_n_s1_ff <= 1'b1;
      rst_n_s2_ff <= rst_n_s1_ff;
    end
  end

  assign rst_n = rst_n_s2_ff;

  // ==========================================================================
  // Pin and strobe synchronisers
  localparam int SYNC_W = PORT_W + 2;

  logic [SYNC_W-1:0] sync_s1_ff;
  logic [SYNC_W-1:0] sync_s2_ff;
  logic [PORT_W-1:0] pin_lvl;
  logic              slv_rd;
  logic              slv_wr;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sync_s1_ff <= '0;
      sync_s2_ff <= '0;
    end else begin
      sync_s1_ff <= {SLAVE_WR, SLAVE_RD, PIN_I};
      sync_s2_ff <= sync_s1_ff;
    end
  end

  assign pin_lvl = sync_s2_ff[PORT_W-1:0];
  assign slv_rd  = sync_s2_ff[PORT_W];
  assign slv_wr  = sync_s2_ff[PORT_W+1];

  // ==========================================================================
  // Bus address phase
  logic                      ap_valid;
  logic [ebpso_pkg::ADDR_W-1:0] ap_addr;
  logic                      dp_wr_ff;
  logic [ebpso_pkg::ADDR_W-1:0] dp_addr_ff;

  assign ap_valid  = HSEL && HTRANS[ebpso_pkg::HTRANS_ACT_BIT] && HREADY;
  assign ap_addr   = HADDR[ebpso_pkg::ADDR_W-1:0];
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // Narrow writes are dropped; only whole words reach the registers.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      dp_wr_ff   <= 1'b0;
      dp_addr_ff <= '0;
    end else if (HREADY) begin
      dp_wr_ff   <= ap_valid && HWRITE && (HSIZE == ebpso_pkg::HSIZE_WORD);
      dp_addr_ff <= ap_addr;
    end
  end

  // ==========================================================================
  // Registers
  logic [PORT_W-1:0] latch_ff;
  logic [PORT_W-1:0] dir_ff;
  logic              mode_ff;
  logic [PORT_W-1:0] slave_in_ff;
  logic [PORT_W-1:0] nxt_latch;
  logic [PORT_W-1:0] nxt_dir;
  logic              nxt_mode;
  logic [PORT_W-1:0] nxt_slave_in;
  logic              slave_en;

  // Dual or quad PWM forces the port back to ordinary I/O.
  assign slave_en = mode_ff && !PWM_MULTI; // [RULE12]

  always_comb begin
    nxt_latch = latch_ff;
    nxt_dir   = dir_ff;
    nxt_mode  = mode_ff;
    if (dp_wr_ff) begin
      if (dp_addr_ff == ebpso_pkg::OFS_PIN_LEVEL) begin
        nxt_latch = HWDATA[PORT_W-1:0]; // [RULE14]
      end else if (dp_addr_ff == ebpso_pkg::OFS_OUT_LATCH) begin
        nxt_latch = HWDATA[PORT_W-1:0]; // [RULE4]
      end else if (dp_addr_ff == ebpso_pkg::OFS_PIN_DIR) begin
        nxt_dir = HWDATA[PORT_W-1:0]; // [RULE5]
      end else if (dp_addr_ff == ebpso_pkg::OFS_AUX_CTRL) begin
        nxt_mode = HWDATA[ebpso_pkg::AUX_MODE_BIT]; // [RULE7]
      end
    end
  end

  always_comb begin
    nxt_slave_in = slave_in_ff;
    if (slave_en && slv_wr && !slv_rd) begin
      nxt_slave_in = pin_lvl; // [RULE10]
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      latch_ff <= ebpso_pkg::RST_LATCH;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      dir_ff <= ebpso_pkg::RST_DIR; // [RULE6]
    end else begin
      dir_ff <= nxt_dir;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= ebpso_pkg::RST_MODE;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      slave_in_ff <= ebpso_pkg::RST_SLAVE_IN;
    end else begin
      slave_in_ff <= nxt_slave_in;
    end
  end

  // ==========================================================================
  // Read data, registered at the address phase from the next-state values
  // so a write in the previous data phase is already visible.
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (ap_addr == ebpso_pkg::OFS_PIN_LEVEL) begin
      nxt_rdata[PORT_W-1:0] = pin_lvl; // [RULE5]
    end else if (ap_addr == ebpso_pkg::OFS_OUT_LATCH) begin
      nxt_rdata[PORT_W-1:0] = nxt_latch; // [RULE4]
    end else if (ap_addr == ebpso_pkg::OFS_PIN_DIR) begin
      nxt_rdata[PORT_W-1:0] = nxt_dir;
    end else if (ap_addr == ebpso_pkg::OFS_AUX_CTRL) begin
      nxt_rdata[ebpso_pkg::AUX_MODE_BIT] = nxt_mode;
    end else if (ap_addr == ebpso_pkg::OFS_SLAVE_IN) begin
      nxt_rdata[PORT_W-1:0] = nxt_slave_in;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA <= 32'h0000_0000;
    end else if (ap_valid && !HWRITE) begin
      HRDATA <= nxt_rdata;
    end
  end

  // ==========================================================================
  // Pin drive
  logic [PORT_W-1:0] mux_o;
  logic [PORT_W-1:0] mux_oe;

  ebpso_pin_mux #(
    .PORT_W   (PORT_W),
    .PWM_CH_N (PWM_CH_N)
  ) u_mux (
    .latch    (latch_ff),
    .dir      (dir_ff),
    .slave_en (slave_en),
    .slave_rd (slv_rd),
    .pwm_act  (PWM_ACTIVE),
    .pwm_val  (PWM_OUT),
    .pin_o    (mux_o),
    .pin_oe   (mux_oe)
  );

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PIN_O  <= '0;
      PIN_OE <= '0; // [RULE6]
    end else begin
      PIN_O  <= mux_o;
      PIN_OE <= mux_oe;
    end
  end

  // ==========================================================================
  // Assertions
  sequence s_latch_rd;
    ap_valid && !HWRITE && (ap_addr == ebpso_pkg::OFS_OUT_LATCH);
  endsequence

  sequence s_port_wr;
    ap_valid && HWRITE && (HSIZE == ebpso_pkg::HSIZE_WORD)
      && (ap_addr == ebpso_pkg::OFS_PIN_LEVEL) ##1 1'b1;
  endsequence

  sequence s_mode_wr;
    ap_valid && HWRITE && (HSIZE == ebpso_pkg::HSIZE_WORD)
      && (ap_addr == ebpso_pkg::OFS_AUX_CTRL) ##1 1'b1;
  endsequence

  property p_dir_drive;
    @(posedge CLK) disable iff (!rst_n)
      !slave_en |=> (PIN_OE[4:0] == ~$past(dir_ff[4:0]))
                    && (PIN_O[4:0] == $past(latch_ff[4:0]));
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("direction drive wrong"); // [RULE2] [RULE3]

  property p_latch_read;
    @(posedge CLK) disable iff (!rst_n)
      s_latch_rd |=> (HRDATA[PORT_W-1:0] == latch_ff);
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch read wrong"); // [RULE4]

  property p_port_read;
    @(posedge CLK) disable iff (!rst_n)
      ap_valid && !HWRITE && (ap_addr == ebpso_pkg::OFS_PIN_LEVEL)
        |=> (HRDATA[PORT_W-1:0] == $past(pin_lvl));
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read wrong"); // [RULE5]

  property p_reset_inputs;
    @(posedge CLK) $rose(rst_n) |-> (PIN_OE == '0) && (dir_ff == ebpso_pkg::RST_DIR);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs"); // [RULE6]

  property p_mode_write;
    @(posedge CLK) disable iff (!rst_n)
      s_mode_wr |=> (mode_ff == $past(HWDATA[ebpso_pkg::AUX_MODE_BIT]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode bit wrong"); // [RULE7]

  property p_slave_idle;
    @(posedge CLK) disable iff (!rst_n)
      slave_en && !slv_rd |=> (PIN_OE[4:0] == 5'h00);
  endproperty
  a_slave_idle: assert property (p_slave_idle) else $error("slave idle drives"); // [RULE8]

  property p_slave_read;
    @(posedge CLK) disable iff (!rst_n)
      slave_en && slv_rd |=> (PIN_OE[4:0] == 5'h1F)
                             && (PIN_O[4:0] == $past(latch_ff[4:0]));
  endproperty
  a_slave_read: assert property (p_slave_read) else $error("slave read drive wrong"); // [RULE9]

  property p_slave_write;
    @(posedge CLK) disable iff (!rst_n)
      slave_en && slv_wr && !slv_rd |=> (slave_in_ff == $past(pin_lvl));
  endproperty
  a_slave_write: assert property (p_slave_write) else $error("slave data lost"); // [RULE10]

  property p_pwm_multi;
    @(posedge CLK) disable iff (!rst_n)
      mode_ff && PWM_MULTI && slv_rd |=> (PIN_OE[4:0] == ~$past(dir_ff[4:0]));
  endproperty
  a_pwm_multi: assert property (p_pwm_multi) else $error("slave not disabled"); // [RULE12]

  property p_pwm_prio;
    @(posedge CLK) disable iff (!rst_n)
      PWM_ACTIVE[0] |=> PIN_OE[5] && (PIN_O[5] == $past(PWM_OUT[0]));
  endproperty
  a_pwm_prio: assert property (p_pwm_prio) else $error("pwm lost priority"); // [RULE11] [RULE13]

  property p_port_write;
    @(posedge CLK) disable iff (!rst_n)
      s_port_wr |=> (latch_ff == $past(HWDATA[PORT_W-1:0])) && $stable(dir_ff);
  endproperty
  a_port_write: assert property (p_port_write) else $error("port write wrong"); // [RULE14]

endmodule // ebpso_top

//--- ebpso_pkg.sv
// Contract
// RULE1 - Eight two-way pins with direction, latch, level.
// RULE2 - Direction bit one turns driver off.
// RULE3 - Direction bit zero drives latch bit out.
// RULE4 - Latch register reads back latch, not pins.
// RULE5 - Pins independent; port read returns pin levels.
// RULE6 - After reset all pins are inputs.
// RULE7 - Control bit four selects parallel slave bus.
// RULE8 - Slave mode overrides the direction bits.
// RULE9 - External read drives pins from latch.
// RULE10 - External write data captured from pins.
// RULE11 - Three pins also carry PWM channels B-D.
// RULE12 - Dual or quad PWM disables slave mode.
// RULE13 - Active PWM channel beats latch and slave data.
// RULE14 - Port register write updates latch, not direction.
package ebpso_pkg;

  // ==========================================================================
  // Register map
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFS_PIN_LEVEL   = 8'h00;
  localparam logic [7:0]  OFS_OUT_LATCH   = 8'h04;
  localparam logic [7:0]  OFS_PIN_DIR     = 8'h08;
  localparam logic [7:0]  OFS_AUX_CTRL    = 8'h0C;
  localparam logic [7:0]  OFS_SLAVE_IN    = 8'h10;

  // ==========================================================================
  // Fields and reset values
  localparam int          PORT_W          = 8;
  localparam int          AUX_MODE_BIT    = 4;
  localparam int          PWM_CH_N        = 3;
  localparam int          PWM_PIN_BASE    = 5;
  localparam logic [7:0]  RST_LATCH       = 8'h00;
  localparam logic [7:0]  RST_DIR         = 8'hFF;
  localparam logic        RST_MODE        = 1'b0;
  localparam logic [7:0]  RST_SLAVE_IN    = 8'h00;

  // ==========================================================================
  // Bus encodings
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;
  localparam int          HTRANS_ACT_BIT  = 1;

endpackage

//--- ebpso_pin_mux.sv
`timescale 1ns/100ps
module ebpso_pin_mux #(
  parameter int PORT_W       = ebpso_pkg::PORT_W,
  parameter int PWM_CH_N     = ebpso_pkg::PWM_CH_N,
  parameter int PWM_PIN_BASE = ebpso_pkg::PWM_PIN_BASE
) (
  // Port state
  input  wire logic [PORT_W-1:0]   latch,
  input  wire logic [PORT_W-1:0]   dir,
  // Slave bus
  input  wire logic                slave_en,
  input  wire logic                slave_rd,
  // PWM channels
  input  wire logic [PWM_CH_N-1:0] pwm_act,
  input  wire logic [PWM_CH_N-1:0] pwm_val,
  // Pin drive
  output logic      [PORT_W-1:0]   pin_o,
  output logic      [PORT_W-1:0]   pin_oe
);

  // ==========================================================================
  // Per-pin priority: PWM, then slave bus, then ordinary port.
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_pin // [RULE1] [RULE5]
      logic pwm_on;
      logic pwm_bit;
      if (gi >= PWM_PIN_BASE && gi < PWM_PIN_BASE + PWM_CH_N) begin : g_pwm // [RULE11]
        assign pwm_on  = pwm_act[gi-PWM_PIN_BASE];
        assign pwm_bit = pwm_val[gi-PWM_PIN_BASE];
      end else begin : g_nopwm
        assign pwm_on  = 1'b0;
        assign pwm_bit = 1'b0;
      end
      always_comb begin
        if (pwm_on) begin // [RULE13]
          pin_oe[gi] = 1'b1;
          pin_o[gi]  = pwm_bit;
        end else if (slave_en) begin // [RULE8]
          pin_oe[gi] = slave_rd; // [RULE9]
          pin_o[gi]  = latch[gi];
        end else begin
          pin_oe[gi] = ~dir[gi]; // [RULE2] [RULE3]
          pin_o[gi]  = latch[gi];
        end
      end
    end
  endgenerate

endmodule // ebpso_pin_mux

//--- ebpso_pin_model.sv
`timescale 1ns/100ps
module ebpso_pin_model (
  // Clock
  input  wire logic       clk,
  // Device side
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe,
  // Far side drive
  input  wire logic [7:0] ext_oe,
  input  wire logic [7:0] ext_val,
  // Resolved pins
  output logic      [7:0] pin_i
);
  // ==========================================================================
  // Floating level
  // Nothing pulls a released pin, so it shows the inverse of its last driven level.
  // Stale data can then never pass for a fresh value.
  logic [7:0] last_ff = 8'h00;
  logic [7:0] held;
  assign held = pin_oe | ext_oe;
  always_ff @(posedge clk) begin
    last_ff <= (held & pin_i) | (~held & last_ff);
  end
  // ==========================================================================
  // Wire resolution
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i])
        pin_i[i] = pin_o[i];
      else if (ext_oe[i])
        pin_i[i] = ext_val[i];
      else
        pin_i[i] = ~last_ff[i];
    end
  end
endmodule // ebpso_pin_model

//--- test_eight_bit_port_with_slave_override.sv
`timescale 1ns/100ps
module test_eight_bit_port_with_slave_override;
  typedef struct { logic [31:0] exp; logic [31:0] msk; } ebpso_note_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  pin_i, pin_o, pin_oe;
  logic        slave_rd = 1'b0;
  logic        slave_wr = 1'b0;
  logic [2:0]  pwm_act = 3'h0;
  logic [2:0]  pwm_out = 3'h0;
  logic        pwm_multi = 1'b0;
  logic [7:0]  ext_oe = 8'h00;
  logic [7:0]  ext_val = 8'h00;
  logic        smp = 1'b0;
  logic        rd_ph = 1'b0;
  int          mismatches = 0;
  int          checks = 0;
  ebpso_note_t note_q[$];
  logic [7:0]  lat, dir, v;
  logic [2:0]  pa, po;

  always #5 clk = ~clk;

  ebpso_top i_ebpso_top (
    .CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe),
    .SLAVE_RD(slave_rd), .SLAVE_WR(slave_wr),
    .PWM_ACTIVE(pwm_act), .PWM_OUT(pwm_out), .PWM_MULTI(pwm_multi)
  );
  ebpso_pin_model i_ebpso_pin_model (
    .clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .ext_oe(ext_oe), .ext_val(ext_val),
    .pin_i(pin_i)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // The slave never stalls today, but the master still polls so a stall cannot slip by.
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        stop_test();
      end
      @(posedge clk);
    end
  endtask

  task automatic bus(logic w, logic [7:0] a, logic [2:0] sz, logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= sz;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    note_q.push_back('{{24'h0, e}, 32'hFFFFFFFF});
    bus(1'b0, a, ebpso_pkg::HSIZE_WORD, 8'h00);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus(1'b1, a, ebpso_pkg::HSIZE_WORD, d);
  endtask

  task automatic pins(logic [7:0] oe, logic [7:0] o, logic [7:0] m);
    note_q.push_back('{{24'h0, oe}, 32'hFF});
    note_q.push_back('{{24'h0, o}, {24'h0, m}});
    @(posedge clk);
    smp <= 1'b1;
    @(posedge clk);
    smp <= 1'b0;
  endtask

  function automatic logic [7:0] mix(logic [7:0] b, logic [2:0] a, logic [2:0] o);
    for (int k = 0; k < 3; k++) begin
      if (a[k])
        b[ebpso_pkg::PWM_PIN_BASE + k] = o[k];
    end
    return b;
  endfunction

  // ==========================================================================
  // Result monitor
  always @(posedge clk) begin
    ebpso_note_t n;
    if (rd_ph && hreadyout === 1'b1) begin
      n = note_q.pop_front();
      check("hrdata", hrdata, n.exp);
      check("hresp", {31'h0, hresp}, 32'h0);
    end
    if (smp) begin
      n = note_q.pop_front();
      check("pin_oe", {24'h0, pin_oe}, n.exp);
      n = note_q.pop_front();
      check("pin_o", {24'h0, pin_o} & n.msk, n.exp & n.msk);
    end
    rd_ph <= hsel && htrans[1] && !hwrite;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'hA590655F));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    pins(8'h00, 8'h00, 8'h00);
    rd(ebpso_pkg::OFS_OUT_LATCH, ebpso_pkg::RST_LATCH);
    rd(ebpso_pkg::OFS_PIN_DIR, ebpso_pkg::RST_DIR);
    rd(ebpso_pkg::OFS_AUX_CTRL, 8'h00);
    rd(ebpso_pkg::OFS_SLAVE_IN, ebpso_pkg::RST_SLAVE_IN);
    lat = $urandom;
    dir = $urandom;
    dir[1:0] = 2'b01;
    v = $urandom;
    wr(ebpso_pkg::OFS_OUT_LATCH, lat);
    wr(ebpso_pkg::OFS_PIN_DIR, dir);
    ext_oe <= dir;
    ext_val <= v;
    pins(~dir, lat, ~dir);
    repeat (2) @(posedge clk);
    rd(ebpso_pkg::OFS_PIN_LEVEL, (lat & ~dir) | (v & dir));
    rd(ebpso_pkg::OFS_OUT_LATCH, lat);
    lat = ~lat;
    wr(ebpso_pkg::OFS_PIN_LEVEL, lat);
    rd(ebpso_pkg::OFS_OUT_LATCH, lat);
    rd(ebpso_pkg::OFS_PIN_DIR, dir);
    wr(8'h14, 8'hAA);
    bus(1'b1, ebpso_pkg::OFS_OUT_LATCH, 3'h0, 8'h5A);
    rd(8'h14, 8'h00);
    rd(ebpso_pkg::OFS_OUT_LATCH, lat);
    ext_oe <= 8'h00;
    wr(ebpso_pkg::OFS_AUX_CTRL, 8'h10);
    rd(ebpso_pkg::OFS_AUX_CTRL, 8'h10);
    pins(8'h00, lat, 8'h00);
    slave_rd <= 1'b1;
    repeat (3) @(posedge clk);
    pins(8'hFF, lat, 8'hFF);
    pwm_act <= 3'h7;
    po = $urandom;
    pwm_out <= po;
    pins(8'hFF, mix(lat, 3'h7, po), 8'hFF);
    slave_rd <= 1'b0;
    pwm_act <= 3'h0;
    repeat (4) @(posedge clk);
    v = $urandom;
    v[0] = ~lat[0];
    ext_oe <= 8'hFF;
    ext_val <= v;
    slave_wr <= 1'b1;
    repeat (5) @(posedge clk);
    slave_wr <= 1'b0;
    repeat (4) @(posedge clk);
    ext_oe <= 8'h00;
    rd(ebpso_pkg::OFS_SLAVE_IN, v);
    slave_rd <= 1'b1;
    slave_wr <= 1'b1;
    repeat (5) @(posedge clk);
    slave_wr <= 1'b0;
    repeat (4) @(posedge clk);
    rd(ebpso_pkg::OFS_SLAVE_IN, v);
    pwm_multi <= 1'b1;
    repeat (3) @(posedge clk);
    pins(~dir, lat, ~dir);
    for (int i = 0; i < 4; i++) begin
      pa = $urandom;
      po = $urandom;
      pwm_act <= pa;
      pwm_out <= po;
      pins(~dir | {pa, 5'h00}, mix(lat, pa, po), ~dir | {pa, 5'h00});
    end
    stop_test();
  end
endmodule // test_eight_bit_port_with_slave_override
